/* flash_pe_pkg.sv */
// Package with register offsets, bit positions, reset values and sizes for the flash program/erase control.
package flash_pe_pkg;
  // Register offsets on the plain register port.
  localparam logic [3:0] ADDR_CTRL_ONE = 4'h0;
  localparam logic [3:0] ADDR_CTRL_TWO = 4'h1;
  localparam logic [3:0] ADDR_BLOCK_ONE = 4'h2;
  localparam logic [3:0] ADDR_BLOCK_TWO = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  // Control register one bit positions.
  localparam int BIT_PROGRAM = 0;
  localparam int BIT_ERASE = 1;
  localparam int BIT_PROGRAM_VERIFY = 2;
  localparam int BIT_ERASE_VERIFY = 3;
  localparam int BIT_WRITE_ENABLE = 6;
  // Control register two bit positions.
  localparam int BIT_ERASE_SETUP = 1;
  localparam int BIT_PROGRAM_SETUP = 0;
  localparam int BIT_ERROR_FLAG = 7;
  // Status register bit positions.
  localparam int BIT_ST_PROGRAMMING = 0;
  localparam int BIT_ST_ERASING = 1;
  localparam int BIT_ST_MODE_OK = 2;
  localparam int BIT_ST_PAGE_FULL = 3;
  // Reset values of the control and block registers.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BLOCK_RESET = 8'h00;
  // Page geometry.
  localparam int PAGE_BYTES = 32;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int FLASH_AW = 16;
  localparam int BLOCKS = 16;
  // Operating mode codes on the mode pins that enable flash.
  localparam logic [1:0] MODE_TWO = 2'h2;
  localparam logic [1:0] MODE_THREE = 2'h3;
endpackage

/* flash_page_latch.sv */
// Page latch holding the 32 program bytes and their base address.
`timescale 1ns/10ps
module flash_page_latch (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic wr,
  input wire logic [flash_pe_pkg::FLASH_AW-1:0] addr,
  input wire logic [7:0] data,
  output logic [flash_pe_pkg::FLASH_AW-1:0] base,
  output logic [flash_pe_pkg::PAGE_BYTES*8-1:0] bytes,
  output logic full
);
  logic [flash_pe_pkg::FLASH_AW-1:0] base_reg, base_next;
  logic [flash_pe_pkg::PAGE_BYTES*8-1:0] bytes_reg, bytes_next;
  logic [5:0] count_reg, count_next;

  // Store each byte at its page offset; the first write fixes the page base.
  always_comb begin
    base_next = base_reg;
    bytes_next = bytes_reg;
    count_next = count_reg;
    if (clear) begin
      count_next = 6'h00;
      bytes_next = {flash_pe_pkg::PAGE_BYTES{flash_pe_pkg::ERASED_BYTE}};
    end else if (wr && count_reg != 6'(flash_pe_pkg::PAGE_BYTES)) begin
      if (count_reg == 6'h00) begin
        base_next = {addr[flash_pe_pkg::FLASH_AW-1:5], 5'h00};
      end
      bytes_next[addr[4:0]*8 +: 8] = data;
      count_next = count_reg + 6'h01;
    end
  end

  // Register the page state.
  always_ff @(posedge clk) begin
    if (rst) begin
      base_reg <= '0;
      bytes_reg <= {flash_pe_pkg::PAGE_BYTES{flash_pe_pkg::ERASED_BYTE}};
      count_reg <= 6'h00;
    end else begin
      base_reg <= base_next;
      bytes_reg <= bytes_next;
      count_reg <= count_next;
    end
  end

  assign base = base_reg;
  assign bytes = bytes_reg;
  assign full = (count_reg == 6'(flash_pe_pkg::PAGE_BYTES));
endmodule // flash_page_latch

/* flash_program_erase_control.sv */
// Flash program and erase control: registers, mode gating, page latch, verify readback and error protection.
// How it works
// - Flash array reads are blocked while write enable is set, outside the verify modes.
// - Two modes, program and erase, entered by setup bit plus mode bit.
// - Device latches 32 consecutive byte writes; software pads with 0xFF.
// - Program runs only while program bit set after program setup.
// - Program verify returns latched address data in 16-bit units.
// - Erase runs only while erase bit set after erase setup.
// - Erase works without prior programming to zero.
// - User program mode only in flash modes 2 and 3.
// - Control bits written from flash code are not guaranteed.
// - Reset and standby clear all control and block registers.
// - Zero in both block registers protects every block.
// - Flash read during program or erase sets error flag, aborts.
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
module flash_program_erase_control (
  input wire logic clk,
  input wire logic rst,
  input wire logic standby,
  input wire logic [1:0] mode_pins,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic flash_wr,
  input wire logic flash_rd,
  input wire logic [flash_pe_pkg::FLASH_AW-1:0] flash_addr,
  input wire logic [7:0] flash_wdata,
  output logic [15:0] flash_rdata,
  output logic flash_rd_blocked,
  input wire logic [15:0] array_rdata,
  output logic [flash_pe_pkg::FLASH_AW-1:0] array_addr,
  output logic array_program,
  output logic array_erase,
  output logic [flash_pe_pkg::BLOCKS-1:0] array_block_sel,
  output logic [flash_pe_pkg::PAGE_BYTES*8-1:0] array_page_data,
  output logic [flash_pe_pkg::FLASH_AW-1:0] array_page_base
);
  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  // Two control and two block-select registers, the verify address and the read data.
  logic [7:0] ctrl_one_reg, ctrl_one_next;
  logic [7:0] ctrl_two_reg, ctrl_two_next;
  logic [7:0] block_one_reg, block_one_next;
  logic [7:0] block_two_reg, block_two_next;
  logic [flash_pe_pkg::FLASH_AW-1:0] verify_addr_reg, verify_addr_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [15:0] frdata_reg, frdata_next;
  logic [1:0] mode_sync_reg;
  logic mode_ok_reg, mode_ok_next;

  // Decoded control bits, named after the modes that they open.
  logic we, program_setup, erase_setup, prog_on, erase_on, program_verify, erase_verify, err;
  logic page_full;
  logic page_clear, page_wr;
  logic [flash_pe_pkg::FLASH_AW-1:0] page_base;
  logic [flash_pe_pkg::PAGE_BYTES*8-1:0] page_bytes;

  // Decode one register address against a write strobe.
  function automatic logic hit(input logic [3:0] a, input logic [3:0] target, input logic strobe);
    hit = strobe && (a == target);
  endfunction

  // Control bit taps; each is read by several of the gates below.
  assign we = ctrl_one_reg[flash_pe_pkg::BIT_WRITE_ENABLE];
  assign program_setup = ctrl_two_reg[flash_pe_pkg::BIT_PROGRAM_SETUP];
  assign erase_setup = ctrl_two_reg[flash_pe_pkg::BIT_ERASE_SETUP];
  assign program_verify = ctrl_one_reg[flash_pe_pkg::BIT_PROGRAM_VERIFY];
  assign erase_verify = ctrl_one_reg[flash_pe_pkg::BIT_ERASE_VERIFY];
  assign err = ctrl_two_reg[flash_pe_pkg::BIT_ERROR_FLAG];
  // The pulse outputs are decoded from the registers every cycle rather than latched, so that
  // clearing any one of the qualifying bits ends the pulse at the very next edge. The wait
  // times between the steps are kept by software; the hardware only refuses the wrong order.
  // program pulse: program runs only with setup, enable and no error.
  assign prog_on = ctrl_one_reg[flash_pe_pkg::BIT_PROGRAM] && program_setup && we && !err;
  // erase pulse: erase runs only with setup, enable and no error.
  assign erase_on = ctrl_one_reg[flash_pe_pkg::BIT_ERASE] && erase_setup && we && !err;
  // Once the error flag is up both pulses stay low although the bits keep their values; only
  // a reset or standby clears the flag, which keeps a runaway program from restarting a pulse.

  // ----------------------------------------------------------------
  // Mode pin capture
  // ----------------------------------------------------------------
  // Three-stage capture of the mode pins; a change counts once stages two and three agree.
  // The mode pins may move at any time, so the gate below follows only a settled value.
  logic [1:0] mode_s1_reg, mode_s2_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_s1_reg <= 2'h0;
      mode_s2_reg <= 2'h0;
      mode_sync_reg <= 2'h0;
    end else begin
      mode_s1_reg <= mode_pins;
      mode_s2_reg <= mode_s1_reg;
      mode_sync_reg <= mode_s2_reg;
    end
  end

  // Between changes the gate keeps its last value, so a pin glitch cannot open it.
  // flash modes: only modes two and three open the controls.
  always_comb begin
    mode_ok_next = mode_ok_reg;
    if (mode_s2_reg == mode_sync_reg) begin
      mode_ok_next = (mode_sync_reg == flash_pe_pkg::MODE_TWO) || (mode_sync_reg == flash_pe_pkg::MODE_THREE);
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Software writes with mode gating, set-guarding and error capture.
  // code origin: the block cannot see where a write came from, so all writes count alike.
  // A write from code in the flash itself is left to software to avoid; with the array blocked
  // such code could not run on anyway.
  always_comb begin
    ctrl_one_next = ctrl_one_reg;
    ctrl_two_next = ctrl_two_reg;
    block_one_next = block_one_reg;
    block_two_next = block_two_reg;
    if (hit(reg_addr, flash_pe_pkg::ADDR_CTRL_ONE, reg_wr) && mode_ok_reg) begin
      // Bits 7, 5 and 4 do not exist and always read zero.
      ctrl_one_next = reg_wdata & 8'h4F;
      // set guard: program bit needs enable and program setup already on.
      // The guard looks at the enable and setup bits as they stand before this write, so an
      // enable set in the same write does not open the pulse bit.
      if (!(we && program_setup)) begin
        ctrl_one_next[flash_pe_pkg::BIT_PROGRAM] = 1'b0;
      end
      // set guard: erase bit needs enable and erase setup already on.
      if (!(we && erase_setup)) begin
        ctrl_one_next[flash_pe_pkg::BIT_ERASE] = 1'b0;
      end
      // verify modes: verify bits need write enable.
      if (!we && !reg_wdata[flash_pe_pkg::BIT_WRITE_ENABLE]) begin
        ctrl_one_next[flash_pe_pkg::BIT_PROGRAM_VERIFY] = 1'b0;
        ctrl_one_next[flash_pe_pkg::BIT_ERASE_VERIFY] = 1'b0;
      end
    end
    // Setup bits written while the enable is clear fall back to zero.
    if (hit(reg_addr, flash_pe_pkg::ADDR_CTRL_TWO, reg_wr) && mode_ok_reg) begin
      // setup bits: setup bits are writable, the error flag is not.
      ctrl_two_next[flash_pe_pkg::BIT_PROGRAM_SETUP] = reg_wdata[flash_pe_pkg::BIT_PROGRAM_SETUP] && we;
      ctrl_two_next[flash_pe_pkg::BIT_ERASE_SETUP] = reg_wdata[flash_pe_pkg::BIT_ERASE_SETUP] && we;
    end
    // Any pattern is taken; software sets a single bit for each erase.
    // block protect: zero in a block register leaves its blocks protected.
    if (hit(reg_addr, flash_pe_pkg::ADDR_BLOCK_ONE, reg_wr) && mode_ok_reg) begin
      block_one_next = reg_wdata;
    end
    if (hit(reg_addr, flash_pe_pkg::ADDR_BLOCK_TWO, reg_wr) && mode_ok_reg) begin
      block_two_next = reg_wdata;
    end
    // The flag is only ever set here; a software write to control two leaves it untouched.
    // error protection: a flash read during program or erase sets the flag.
    if (flash_rd && (prog_on || erase_on)) begin
      ctrl_two_next[flash_pe_pkg::BIT_ERROR_FLAG] = 1'b1;
    end
  end

  // Standby clears the same control and block registers as reset, the error flag included.
  // reset and standby: both control and both block registers return to reset.
  always_ff @(posedge clk) begin
    if (rst || standby) begin
      ctrl_one_reg <= flash_pe_pkg::CTRL_RESET;
      ctrl_two_reg <= flash_pe_pkg::CTRL_RESET;
      block_one_reg <= flash_pe_pkg::BLOCK_RESET;
      block_two_reg <= flash_pe_pkg::BLOCK_RESET;
    end else begin
      ctrl_one_reg <= ctrl_one_next;
      ctrl_two_reg <= ctrl_two_next;
      block_one_reg <= block_one_next;
      block_two_reg <= block_two_next;
    end
  end

  // Register the mode gate; it stays closed from reset until the pins have settled.
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_ok_reg <= 1'b0;
    end else begin
      mode_ok_reg <= mode_ok_next;
    end
  end

  // ----------------------------------------------------------------
  // Page latch and verify address
  // ----------------------------------------------------------------
  // page latch: byte writes with enable and no mode active fill the page.
  // A write in a setup or verify mode is a dummy write and must not disturb the page, and
  // clearing the enable empties the latch so that the next page starts from all ones.
  assign page_wr = flash_wr && we && !program_verify && !erase_verify && !program_setup && !erase_setup;
  assign page_clear = !we;

  // The page latch keeps the 32 bytes and their base for the array to program.
  flash_page_latch u_page (
    .clk(clk),
    .rst(rst),
    .clear(page_clear),
    .wr(page_wr),
    .addr(flash_addr),
    .data(flash_wdata),
    .base(page_base),
    .bytes(page_bytes),
    .full(page_full)
  );

  // verify address: a dummy write in a verify mode latches the read address.
  // Bit 0 is dropped because verify data come as 16-bit words.
  always_comb begin
    verify_addr_next = verify_addr_reg;
    if (flash_wr && (program_verify || erase_verify)) begin
      verify_addr_next = {flash_addr[flash_pe_pkg::FLASH_AW-1:1], 1'b0};
    end
  end

  // Register the latched verify address.
  always_ff @(posedge clk) begin
    if (rst) begin
      verify_addr_reg <= '0;
    end else begin
      verify_addr_reg <= verify_addr_next;
    end
  end

  // ----------------------------------------------------------------
  // Array side
  // ----------------------------------------------------------------
  // verify read: in verify modes the array is addressed by the latched address.
  // Outside the verify modes the bus address passes straight through to the array.
  assign array_addr = (program_verify || erase_verify) ? verify_addr_reg : flash_addr;
  assign array_program = prog_on;
  assign array_erase = erase_on;
  // direct erase: the selected block goes straight to erase with no preprogramming.
  // no block: with both block registers at zero the select stays all zero while erasing.
  assign array_block_sel = erase_on ? {block_two_reg, block_one_reg} : '0;
  assign array_page_data = page_bytes;
  assign array_page_base = page_base;

  // read block: with write enable set, normal array reads are refused.
  // The verify modes are the one way to read the array while the enable is set.
  assign flash_rd_blocked = we && !program_verify && !erase_verify;

  // Flash read data: 16-bit verify words or normal reads, zero when blocked.
  // A blocked read returns zero rather than stale data, so a read in the wrong mode is plain.
  always_comb begin
    frdata_next = frdata_reg;
    if (flash_rd) begin
      frdata_next = flash_rd_blocked ? 16'h0000 : array_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  // Read data for the cycle after the read strobe; unmapped offsets read zero.
  // The status word shows the live pulses, the mode gate and a full page.
  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        flash_pe_pkg::ADDR_CTRL_ONE: rdata_next = ctrl_one_reg;
        flash_pe_pkg::ADDR_CTRL_TWO: rdata_next = ctrl_two_reg;
        flash_pe_pkg::ADDR_BLOCK_ONE: rdata_next = block_one_reg;
        flash_pe_pkg::ADDR_BLOCK_TWO: rdata_next = block_two_reg;
        flash_pe_pkg::ADDR_STATUS: begin
          rdata_next[flash_pe_pkg::BIT_ST_PROGRAMMING] = prog_on;
          rdata_next[flash_pe_pkg::BIT_ST_ERASING] = erase_on;
          rdata_next[flash_pe_pkg::BIT_ST_MODE_OK] = mode_ok_reg;
          rdata_next[flash_pe_pkg::BIT_ST_PAGE_FULL] = page_full;
        end
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Register both read ports; the flash word holds until the next flash read.
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
      frdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
      frdata_reg <= frdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign flash_rdata = frdata_reg;
endmodule // flash_program_erase_control

/* flash_pe_checker_properties.sv */
// Concurrent checks on the ports of the flash program and erase control.
`timescale 1ns/10ps
module flash_pe_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic standby,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic flash_rd,
  input wire logic [15:0] flash_rdata,
  input wire logic flash_rd_blocked,
  input wire logic [15:0] array_rdata,
  input wire logic array_program,
  input wire logic array_erase
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  // A flash read while the programming pulse is active.
  sequence s_rd_busy;
    array_program && flash_rd;
  endsequence
  // A flash read that is let through to the array.
  sequence s_rd_open;
    flash_rd && !flash_rd_blocked;
  endsequence
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  property p_blk_rd;
    flash_rd && flash_rd_blocked |=> flash_rdata == 16'h0000;
  endproperty
  property p_vdata;
    s_rd_open |=> flash_rdata == $past(array_rdata);
  endproperty
  property p_hold;
    !$past(rst) && !$past(flash_rd) |-> $stable(flash_rdata);
  endproperty
  property p_prog_cause;
    $rose(array_program) |-> $past(reg_wr && reg_addr == flash_pe_pkg::ADDR_CTRL_ONE &&
      reg_wdata[flash_pe_pkg::BIT_PROGRAM] && reg_wdata[flash_pe_pkg::BIT_WRITE_ENABLE]);
  endproperty
  property p_erase_cause;
    $rose(array_erase) |-> $past(reg_wr && reg_addr == flash_pe_pkg::ADDR_CTRL_ONE &&
      reg_wdata[flash_pe_pkg::BIT_ERASE] && reg_wdata[flash_pe_pkg::BIT_WRITE_ENABLE]);
  endproperty
  property p_abort;
    s_rd_busy |=> !array_program [*8];
  endproperty
  property p_standby;
    standby |=> !array_program && !array_erase && !flash_rd_blocked;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("register read data not zero when idle");
  a_blk_rd: assert property (p_blk_rd) else $error("blocked flash read returned data");
  a_vdata: assert property (p_vdata) else $error("flash read data differs from array");
  a_hold: assert property (p_hold) else $error("flash read data changed without a read");
  a_prog_cause: assert property (p_prog_cause) else $error("program pulse without its write");
  a_erase_cause: assert property (p_erase_cause) else $error("erase pulse without its write");
  a_abort: assert property (p_abort) else $error("program not aborted by flash read");
  a_standby: assert property (p_standby) else $error("standby left control bits set");
endmodule // flash_pe_checker
bind flash_program_erase_control flash_pe_checker u_chk (.clk(clk), .rst(rst), .standby(standby),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .flash_rd(flash_rd), .flash_rdata(flash_rdata), .flash_rd_blocked(flash_rd_blocked),
  .array_rdata(array_rdata), .array_program(array_program), .array_erase(array_erase));

/* array_model.sv */
// Behavioural flash array standing behind the control block.
`timescale 1ns/10ps
module array_model (
  input wire logic clk,
  input wire logic [15:0] array_addr,
  input wire logic array_program,
  input wire logic array_erase,
  input wire logic [15:0] array_block_sel,
  input wire logic [255:0] array_page_data,
  input wire logic [15:0] array_page_base,
  output logic [15:0] array_rdata
);
  logic [7:0] mem [0:65535];
  // Cells start at zero so an erase must work without preprogramming.
  initial for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
  // program and erase
  // Programming only clears bits; erase needs a selected block.
  always @(posedge clk) begin
    if (array_erase && array_block_sel != 16'h0000)
      for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
    if (array_program)
      for (int i = 0; i < 32; i++) mem[array_page_base + 16'(i)] &= array_page_data[8*i+:8];
  end
  // word reads
  // Word reads return the even byte in the upper half.
  assign array_rdata = {mem[{array_addr[15:1], 1'b0}], mem[{array_addr[15:1], 1'b1}]};
endmodule // array_model

/* tb_top.sv */
// Self-checking bench for the flash program and erase control.
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0, rst = 1'b1, standby = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, flash_wr = 1'b0, flash_rd = 1'b0;
  logic [1:0] mode_pins = 2'h2;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, flash_wdata = 8'h00;
  logic [15:0] flash_addr = 16'h0000, flash_rdata, array_rdata, array_addr, base, array_block_sel, array_page_base;
  logic flash_rd_blocked, array_program, array_erase, rd_d = 1'b0, frd_d = 1'b0;
  logic [255:0] array_page_data, exp_pd;
  logic [15:0] exp_q[$];
  logic [7:0] pg[32];
  int err_count = 0, comparisons = 0;
  always #2 clk = ~clk;
  flash_program_erase_control u_dut (.clk(clk), .rst(rst), .standby(standby), .mode_pins(mode_pins),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flash_wr(flash_wr), .flash_rd(flash_rd), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_rdata(flash_rdata), .flash_rd_blocked(flash_rd_blocked), .array_rdata(array_rdata),
    .array_addr(array_addr), .array_program(array_program), .array_erase(array_erase),
    .array_block_sel(array_block_sel), .array_page_data(array_page_data), .array_page_base(array_page_base));
  array_model u_arr (.clk(clk), .array_addr(array_addr), .array_program(array_program), .array_erase(array_erase),
    .array_block_sel(array_block_sel), .array_page_data(array_page_data), .array_page_base(array_page_base),
    .array_rdata(array_rdata));
  // Counts a comparison and reports a mismatch.
  task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // One cycle access: 0 reg write, 1 reg read, 2 flash write, 3 flash read.
  task automatic bus(input int k, input logic [15:0] a, input logic [7:0] d, input logic [15:0] e);
    @(posedge clk);
    reg_wr <= (k == 0);
    reg_rd <= (k == 1);
    flash_wr <= (k == 2);
    flash_rd <= (k == 3);
    reg_addr <= a[3:0];
    flash_addr <= a;
    reg_wdata <= d;
    flash_wdata <= d;
    if (k == 1 || k == 3) exp_q.push_back(e);
    @(posedge clk);
    {reg_wr, reg_rd, flash_wr, flash_rd} <= 4'h0;
  endtask
  // Holds reset for eight cycles, then lets the mode pins settle.
  task automatic do_reset;
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Compares each read result with the oldest expected value.
  always @(posedge clk) begin
    if (rd_d || frd_d) chk(rd_d ? {8'h00, reg_rdata} : flash_rdata, exp_q.pop_front());
    rd_d <= reg_rd;
    frd_d <= flash_rd;
  end
  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_of_test;
  end
  // Main sequence.
  initial begin
    void'($urandom(32'h2D206FD7));
    do_reset;
    for (int i = 0; i < 6; i++) bus(1, 16'(i), 8'h00, (i == 4) ? 16'h0004 : 16'h0000);
    $display("test reset values done");
    bus(0, 16'h0000, 8'hF3, 0);
    bus(1, 16'h0000, 8'h00, 16'h0040);
    bus(0, 16'h0002, 8'h01, 0);
    bus(0, 16'h0001, 8'h02, 0);
    bus(0, 16'h0000, 8'h42, 0);
    @(negedge clk);
    chk({array_erase, array_block_sel}, 17'h10001);
    bus(1, 16'h0004, 8'h00, 16'h0006);
    bus(0, 16'h0000, 8'h40, 0);
    bus(0, 16'h0001, 8'h00, 0);
    bus(0, 16'h0000, 8'h48, 0);
    bus(2, 16'h0100, 8'hFF, 0);
    bus(3, 16'h0000, 8'h00, 16'hFFFF);
    bus(0, 16'h0000, 8'h00, 0);
    $display("test erase done");
    base = {8'h10, 3'($urandom_range(7)), 5'h00};
    bus(0, 16'h0000, 8'h40, 0);
    for (int i = 0; i < 32; i++) begin
      pg[i] = (i == 31) ? 8'hFF : 8'($urandom);
      exp_pd[8*i+:8] = pg[i];
      bus(2, base + 16'(i), pg[i], 0);
    end
    @(negedge clk);
    chk(array_page_data, exp_pd);
    chk(array_page_base, base);
    chk(flash_rd_blocked, 1'b1);
    bus(3, base, 8'h00, 16'h0000);
    bus(1, 16'h0004, 8'h00, 16'h000C);
    bus(0, 16'h0001, 8'h01, 0);
    bus(0, 16'h0000, 8'h41, 0);
    @(negedge clk);
    chk(array_program, 1'b1);
    bus(1, 16'h0004, 8'h00, 16'h000D);
    bus(0, 16'h0000, 8'h40, 0);
    bus(0, 16'h0001, 8'h00, 0);
    bus(0, 16'h0000, 8'h44, 0);
    bus(2, base + 16'h0003, 8'hFF, 0);
    @(negedge clk);
    chk({array_addr, flash_rd_blocked}, {base + 16'h0002, 1'b0});
    bus(3, 16'h0000, 8'h00, {pg[2], pg[3]});
    bus(0, 16'h0000, 8'h00, 0);
    $display("test program done");
    bus(0, 16'h0000, 8'h40, 0);
    bus(0, 16'h0001, 8'h01, 0);
    bus(0, 16'h0000, 8'h41, 0);
    bus(3, 16'h0000, 8'h00, 16'h0000);
    @(negedge clk);
    chk(array_program, 1'b0);
    bus(1, 16'h0001, 8'h00, 16'h0081);
    do_reset;
    bus(1, 16'h0001, 8'h00, 16'h0000);
    bus(0, 16'h0000, 8'h40, 0);
    bus(0, 16'h0001, 8'h02, 0);
    bus(0, 16'h0000, 8'h42, 0);
    @(negedge clk);
    chk({array_erase, array_block_sel}, 17'h10000);
    @(posedge clk);
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    bus(1, 16'h0000, 8'h00, 16'h0000);
    $display("test error and standby done");
    mode_pins <= 2'h0;
    repeat (6) @(posedge clk);
    bus(0, 16'h0000, 8'h40, 0);
    bus(1, 16'h0000, 8'h00, 16'h0000);
    bus(1, 16'h0004, 8'h00, 16'h0000);
    mode_pins <= 2'h3;
    repeat (6) @(posedge clk);
    bus(1, 16'h0004, 8'h00, 16'h0004);
    repeat (3) @(posedge clk);
    $display("test mode gating done");
    end_of_test;
  end
endmodule // tb_top
